// *** include/tmr_pkg.sv ***
// constants, field positions and types shared by the dual timer block
// assumes a 32-bit Avalon-MM slave port; register index times four is the byte address
package tmr_pkg;
  // register indices; byte address is index times four
  localparam logic [7:0] IDX_RUN_FLAGS  = 8'h88;
  localparam logic [7:0] IDX_MODE_CTRL  = 8'h89;
  localparam logic [7:0] IDX_A_LOW      = 8'h8A;
  localparam logic [7:0] IDX_B_LOW      = 8'h8B;
  localparam logic [7:0] IDX_A_HIGH     = 8'h8C;
  localparam logic [7:0] IDX_B_HIGH     = 8'h8D;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h90;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h91;
  // run/flag register bit positions
  localparam int BIT_TF_B = 7;
  localparam int BIT_TR_B = 6;
  localparam int BIT_TF_A = 5;
  localparam int BIT_TR_A = 4;
  localparam int BIT_IE_B = 3;
  localparam int BIT_IT_B = 2;
  localparam int BIT_IE_A = 1;
  localparam int BIT_IT_A = 0;
  // mode control field positions (timer B upper nibble, timer A lower)
  localparam int BIT_GATE_B = 7;
  localparam int BIT_SRC_B  = 6;
  localparam int MODE_B_LSB = 4;
  localparam int BIT_GATE_A = 3;
  localparam int BIT_SRC_A  = 2;
  localparam int MODE_A_LSB = 0;
  // event index in status/mask/ack vectors
  localparam int EV_TMR_A = 0;
  localparam int EV_TMR_B = 1;
  localparam int EV_PIN_A = 2;
  localparam int EV_PIN_B = 3;
  // reset values and limits
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [7:0] BYTE_MAX  = 8'hFF;
  localparam logic [4:0] PRESC_MAX = 5'h1F;
  localparam logic [3:0] EV_RST    = 4'h0;
  // timer count modes
  typedef enum logic [1:0] {
    MODE_PRESC = 2'b00,
    MODE_WIDE  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } tmr_mode_e;
  // bus answer state, gray along idle -> ack -> idle
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_e;
  // true when a byte address selects a register index
  function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
    reg_hit = (addr == {2'b00, idx, 2'b00});
  endfunction : reg_hit
endpackage : tmr_pkg

// *** include/tmr_if.sv ***
// carrier between the timer controller and one timer count unit
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface tmr_if;
  import tmr_pkg::*;
  tmr_mode_e  mode;      // count mode of this timer
  logic       low_tick;  // advance the low byte path
  logic       high_tick; // advance high byte in split mode
  logic       wr_low;    // software write to low byte
  logic       wr_high;   // software write to high byte
  logic [7:0] wdata;     // software write data
  logic [7:0] low_q;     // low byte value
  logic [7:0] high_q;    // high byte value
  logic       ovf_main;  // main counter overflow pulse
  logic       ovf_high;  // split high byte overflow pulse
  modport ctrl (output mode, low_tick, high_tick, wr_low, wr_high, wdata,
                input low_q, high_q, ovf_main, ovf_high);
  modport unit (input mode, low_tick, high_tick, wr_low, wr_high, wdata,
                output low_q, high_q, ovf_main, ovf_high);
endinterface : tmr_if

// *** core/tmr_count_unit.sv ***
// one timer's low and high count bytes and their four count modes
// assumes ticks are single-cycle pulses already gated by run and pin gating
`timescale 1ns/100ps
module tmr_count_unit
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // controller side
  tmr_if.unit      tif
);
  logic [7:0] low_ff;  // low byte
  logic [7:0] high_ff; // high byte

  assign tif.low_q  = low_ff;
  assign tif.high_q = high_ff;

  // low byte; a software write beats a count in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      low_ff <= BYTE_RST;
    end else if (tif.wr_low) begin
      low_ff <= tif.wdata;
    end else if (tif.low_tick) begin
      case (tif.mode)
        MODE_PRESC: low_ff[4:0] <= 5'(low_ff[4:0] + 5'h01);
        MODE_RELOAD: low_ff <= (low_ff == BYTE_MAX) ? high_ff : 8'(low_ff + 8'h01);
        default: low_ff <= 8'(low_ff + 8'h01);
      endcase
    end
  end

  // high byte; holds the reload value in reload mode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      high_ff <= BYTE_RST;
    end else if (tif.wr_high) begin
      high_ff <= tif.wdata;
    end else begin
      case (tif.mode)
        MODE_PRESC: begin
          if (tif.low_tick && low_ff[4:0] == PRESC_MAX) high_ff <= 8'(high_ff + 8'h01);
        end
        MODE_WIDE: begin
          if (tif.low_tick && low_ff == BYTE_MAX) high_ff <= 8'(high_ff + 8'h01);
        end
        MODE_SPLIT: begin
          if (tif.high_tick) high_ff <= 8'(high_ff + 8'h01);
        end
        default: high_ff <= high_ff; // reload value kept
      endcase
    end
  end

  // overflow pulses, one per wrap
  always_comb begin
    case (tif.mode)
      MODE_PRESC: tif.ovf_main = tif.low_tick && low_ff[4:0] == PRESC_MAX
                                 && high_ff == BYTE_MAX;
      MODE_WIDE:  tif.ovf_main = tif.low_tick && low_ff == BYTE_MAX && high_ff == BYTE_MAX;
      default:    tif.ovf_main = tif.low_tick && low_ff == BYTE_MAX;
    endcase
    tif.ovf_high = tif.high_tick && tif.mode == MODE_SPLIT && high_ff == BYTE_MAX;
  end

  // reload step: a wrap loads the held high byte
  sequence s_reload_wrap;
    tif.mode == MODE_RELOAD && tif.low_tick && low_ff == BYTE_MAX && !tif.wr_low;
  endsequence
  chk_reload_from_high: assert property (@(posedge clock) disable iff (sys_rst)
    s_reload_wrap |=> low_ff == $past(high_ff))
    else $error("reload did not copy the high byte");
endmodule : tmr_count_unit

// *** core/dual_timer_counter_ext_int.sv ***
// two 16-bit timer/counters with external interrupt pin sensing and flags
// assumes an Avalon-MM master on clock; pins are asynchronous to clock
`timescale 1ns/100ps
module dual_timer_counter_ext_int
  import tmr_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // avalon-mm slave
  input  wire logic [11:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // external pins
  input  wire logic        ext_irq_pin_a,
  input  wire logic        ext_irq_pin_b,
  input  wire logic        count_input_a,
  input  wire logic        count_input_b,
  // service routine entry acknowledges, one-cycle pulses
  input  wire logic [3:0]  vector_ack,
  // interrupt requests toward the processor
  output logic             timer_a_irq_req,
  output logic             timer_b_irq_req,
  output logic             pin_a_irq_req,
  output logic             pin_b_irq_req,
  output logic             irq
);
  // pin order inside the synchroniser vectors
  localparam int PIN_IRQ_A = 0;
  localparam int PIN_IRQ_B = 1;
  localparam int PIN_CNT_A = 2;
  localparam int PIN_CNT_B = 3;

  bus_state_e bus_state_ff;  // bus answer phase
  logic [31:0] readdata_ff;  // registered read data
  logic [31:0] nxt_readdata; // read mux result
  logic [3:0] pin_meta_ff;   // first sync stage, read only by stage two
  logic [3:0] pin_sync_ff;   // second sync stage
  logic [3:0] pin_prev_ff;   // delayed copy for edge detect
  logic [3:0] pin_fall;      // falling edge pulses
  logic       div_ff;        // half-rate tick for timer mode
  logic [7:0] mode_ctrl_ff;  // gating, source and mode fields
  logic       run_a_ff;      // timer A run bit
  logic       run_b_ff;      // timer B run bit
  logic       sense_a_ff;    // pin A sense select
  logic       sense_b_ff;    // pin B sense select
  logic       tf_a_ff;       // timer A overflow flag
  logic       tf_b_ff;       // timer B overflow flag
  logic       ie_a_ff;       // pin A edge flag
  logic       ie_b_ff;       // pin B edge flag
  logic [3:0] irq_status_ff; // sticky event bits
  logic [3:0] irq_mask_ff;   // event enables
  logic       wr_fire;       // write takes effect this edge
  logic       wr_byte0;      // write with low lane enabled
  logic       en_a;          // timer A allowed to count
  logic       en_b;          // timer B allowed to count
  logic       tf_a_set;      // timer A overflow event
  logic       tf_b_set;      // timer B overflow event
  logic       ie_a_set;      // pin A falling edge in edge mode
  logic       ie_b_set;      // pin B falling edge in edge mode
  logic [3:0] events;        // events feeding the status register
  logic [7:0] run_flags;     // run/flag register read view
  tmr_mode_e  mode_a;        // timer A mode
  tmr_mode_e  mode_b;        // timer B mode

  tmr_if tif_a ();
  tmr_if tif_b ();

  // timer A count unit
  tmr_count_unit u_tmr_a (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tif     (tif_a)
  );

  // timer B count unit
  tmr_count_unit u_tmr_b (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tif     (tif_b)
  );

  // ---- bus slave: one wait cycle, then the answer edge ----
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_state_ff <= BUS_IDLE;
    end else begin
      case (bus_state_ff)
        BUS_IDLE: if (read || write) bus_state_ff <= BUS_ACK;
        BUS_ACK:  bus_state_ff <= BUS_IDLE;
        default:  bus_state_ff <= BUS_IDLE;
      endcase
    end
  end

  // waitrequest drops in the ack phase; the master releases after it
  assign waitrequest = (read || write) && bus_state_ff != BUS_ACK;
  assign wr_fire     = write && bus_state_ff == BUS_ACK;
  assign wr_byte0    = wr_fire && byteenable[0];
  assign readdata    = readdata_ff;

  // run/flag register view
  assign run_flags = {tf_b_ff, run_b_ff, tf_a_ff, run_a_ff,
                      ie_b_ff, sense_b_ff, ie_a_ff, sense_a_ff};

  // read mux; unmapped addresses read zero
  always_comb begin
    nxt_readdata = 32'h0000_0000;
    if (reg_hit(address, IDX_RUN_FLAGS))  nxt_readdata[7:0] = run_flags;
    if (reg_hit(address, IDX_MODE_CTRL))  nxt_readdata[7:0] = mode_ctrl_ff;
    if (reg_hit(address, IDX_A_LOW))      nxt_readdata[7:0] = tif_a.low_q;
    if (reg_hit(address, IDX_B_LOW))      nxt_readdata[7:0] = tif_b.low_q;
    if (reg_hit(address, IDX_A_HIGH))     nxt_readdata[7:0] = tif_a.high_q;
    if (reg_hit(address, IDX_B_HIGH))     nxt_readdata[7:0] = tif_b.high_q;
    if (reg_hit(address, IDX_IRQ_STATUS)) nxt_readdata[3:0] = irq_status_ff;
    if (reg_hit(address, IDX_IRQ_MASK))   nxt_readdata[3:0] = irq_mask_ff;
  end

  // read data captured in the wait cycle so it stands at the answer edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      readdata_ff <= 32'h0000_0000;
    end else if (read && bus_state_ff == BUS_IDLE) begin
      readdata_ff <= nxt_readdata;
    end
  end

  // ---- pin synchronisers and edge detect ----
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_meta_ff <= 4'hF;
      pin_sync_ff <= 4'hF;
      pin_prev_ff <= 4'hF;
    end else begin
      pin_meta_ff <= {count_input_b, count_input_a, ext_irq_pin_b, ext_irq_pin_a};
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  // one pulse per settled high-to-low transition
  assign pin_fall = pin_prev_ff & ~pin_sync_ff;

  // free-running half-rate divider for timer mode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_ff <= 1'b0;
    end else begin
      div_ff <= ~div_ff;
    end
  end

  // ---- mode control register ----
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_ctrl_ff <= BYTE_RST;
    end else if (wr_byte0 && reg_hit(address, IDX_MODE_CTRL)) begin
      mode_ctrl_ff <= writedata[7:0];
    end
  end

  assign mode_a = tmr_mode_e'(mode_ctrl_ff[MODE_A_LSB +: 2]);
  assign mode_b = tmr_mode_e'(mode_ctrl_ff[MODE_B_LSB +: 2]);

  // count enables: run bit, optionally gated by the interrupt pin level
  assign en_a = run_a_ff && (!mode_ctrl_ff[BIT_GATE_A] || pin_sync_ff[PIN_IRQ_A]);
  assign en_b = run_b_ff && (!mode_ctrl_ff[BIT_GATE_B] || pin_sync_ff[PIN_IRQ_B]);

  // timer A drive; split high byte borrows timer B's run bit
  assign tif_a.mode      = mode_a;
  assign tif_a.low_tick  = en_a && (mode_ctrl_ff[BIT_SRC_A] ? pin_fall[PIN_CNT_A]
                                                             : div_ff);
  assign tif_a.high_tick = mode_a == MODE_SPLIT && run_b_ff && div_ff;
  assign tif_a.wr_low    = wr_byte0 && reg_hit(address, IDX_A_LOW);
  assign tif_a.wr_high   = wr_byte0 && reg_hit(address, IDX_A_HIGH);
  assign tif_a.wdata     = writedata[7:0];

  // timer B drive; mode 11 freezes both bytes
  assign tif_b.mode      = mode_b;
  assign tif_b.low_tick  = mode_b != MODE_SPLIT && en_b
                           && (mode_ctrl_ff[BIT_SRC_B] ? pin_fall[PIN_CNT_B] : div_ff);
  assign tif_b.high_tick = 1'b0;
  assign tif_b.wr_low    = wr_byte0 && reg_hit(address, IDX_B_LOW);
  assign tif_b.wr_high   = wr_byte0 && reg_hit(address, IDX_B_HIGH);
  assign tif_b.wdata     = writedata[7:0];

  // ---- run and sense bits ----
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      run_a_ff   <= 1'b0;
      run_b_ff   <= 1'b0;
      sense_a_ff <= 1'b0;
      sense_b_ff <= 1'b0;
    end else if (wr_byte0 && reg_hit(address, IDX_RUN_FLAGS)) begin
      run_a_ff   <= writedata[BIT_TR_A];
      run_b_ff   <= writedata[BIT_TR_B];
      sense_a_ff <= writedata[BIT_IT_A];
      sense_b_ff <= writedata[BIT_IT_B];
    end
  end

  // hardware set events
  assign tf_a_set = tif_a.ovf_main;
  assign tf_b_set = tif_b.ovf_main || tif_a.ovf_high;
  assign ie_a_set = sense_a_ff && pin_fall[PIN_IRQ_A];
  assign ie_b_set = sense_b_ff && pin_fall[PIN_IRQ_B];

  // flags: set beats vector clear, which beats a software write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tf_a_ff <= 1'b0;
    end else if (tf_a_set) begin
      tf_a_ff <= 1'b1;
    end else if (vector_ack[EV_TMR_A]) begin
      tf_a_ff <= 1'b0;
    end else if (wr_byte0 && reg_hit(address, IDX_RUN_FLAGS)) begin
      tf_a_ff <= writedata[BIT_TF_A];
    end
  end

  // timer B overflow flag
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tf_b_ff <= 1'b0;
    end else if (tf_b_set) begin
      tf_b_ff <= 1'b1;
    end else if (vector_ack[EV_TMR_B]) begin
      tf_b_ff <= 1'b0;
    end else if (wr_byte0 && reg_hit(address, IDX_RUN_FLAGS)) begin
      tf_b_ff <= writedata[BIT_TF_B];
    end
  end

  // pin A edge flag
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ie_a_ff <= 1'b0;
    end else if (ie_a_set) begin
      ie_a_ff <= 1'b1;
    end else if (vector_ack[EV_PIN_A]) begin
      ie_a_ff <= 1'b0;
    end else if (wr_byte0 && reg_hit(address, IDX_RUN_FLAGS)) begin
      ie_a_ff <= writedata[BIT_IE_A];
    end
  end

  // pin B edge flag
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ie_b_ff <= 1'b0;
    end else if (ie_b_set) begin
      ie_b_ff <= 1'b1;
    end else if (vector_ack[EV_PIN_B]) begin
      ie_b_ff <= 1'b0;
    end else if (wr_byte0 && reg_hit(address, IDX_RUN_FLAGS)) begin
      ie_b_ff <= writedata[BIT_IE_B];
    end
  end

  // request lines: level mode requests while the pin is low, edge mode follows the flag
  assign timer_a_irq_req = tf_a_ff;
  assign timer_b_irq_req = tf_b_ff;
  assign pin_a_irq_req   = sense_a_ff ? ie_a_ff : !pin_sync_ff[PIN_IRQ_A];
  assign pin_b_irq_req   = sense_b_ff ? ie_b_ff : !pin_sync_ff[PIN_IRQ_B];

  // ---- sticky status, write one to clear, set wins ----
  assign events = {ie_b_set, ie_a_set, tf_b_set, tf_a_set};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_status_ff <= EV_RST;
    end else if (wr_byte0 && reg_hit(address, IDX_IRQ_STATUS)) begin
      irq_status_ff <= (irq_status_ff & ~writedata[3:0]) | events;
    end else begin
      irq_status_ff <= irq_status_ff | events;
    end
  end

  // interrupt mask
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_mask_ff <= EV_RST;
    end else if (wr_byte0 && reg_hit(address, IDX_IRQ_MASK)) begin
      irq_mask_ff <= writedata[3:0];
    end
  end

  // level output while any enabled status bit stands
  assign irq = |(irq_status_ff & irq_mask_ff);

  // ---- checks ----
  sequence s_fall_a_edge_mode;
    sense_a_ff && pin_fall[PIN_IRQ_A];
  endsequence
  sequence s_fall_b_edge_mode;
    sense_b_ff && pin_fall[PIN_IRQ_B];
  endsequence

  chk_pin_a_edge: assert property (@(posedge clock) disable iff (sys_rst)
    s_fall_a_edge_mode |=> ie_a_ff && pin_a_irq_req)
    else $error("pin A falling edge not flagged");
  chk_pin_b_edge: assert property (@(posedge clock) disable iff (sys_rst)
    s_fall_b_edge_mode |=> ie_b_ff && pin_b_irq_req)
    else $error("pin B falling edge not flagged");
  chk_vector_clear: assert property (@(posedge clock) disable iff (sys_rst)
    vector_ack[EV_PIN_A] && !ie_a_set |=> !ie_a_ff)
    else $error("pin A flag not cleared by vector");
  chk_level_a: assert property (@(posedge clock) disable iff (sys_rst)
    !sense_a_ff |-> pin_a_irq_req == !pin_sync_ff[PIN_IRQ_A])
    else $error("pin A level request wrong");
  chk_level_b: assert property (@(posedge clock) disable iff (sys_rst)
    !sense_b_ff && !pin_sync_ff[PIN_IRQ_B] |-> pin_b_irq_req)
    else $error("pin B low level not requesting");
  chk_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
    mode_ctrl_ff[BIT_GATE_A] && !pin_sync_ff[PIN_IRQ_A] |-> !tif_a.low_tick)
    else $error("timer A counted with gate pin low");
  chk_gate_b: assert property (@(posedge clock) disable iff (sys_rst)
    !run_b_ff || (mode_ctrl_ff[BIT_GATE_B] && !pin_sync_ff[PIN_IRQ_B]) |-> !tif_b.low_tick)
    else $error("timer B counted while disabled");
  chk_half_rate: assert property (@(posedge clock) disable iff (sys_rst)
    tif_a.low_tick && !mode_ctrl_ff[BIT_SRC_A] |=> !tif_a.low_tick)
    else $error("timer A ticked on consecutive clocks");
  chk_ovf_flag: assert property (@(posedge clock) disable iff (sys_rst)
    tf_b_set |=> tf_b_ff ##0 timer_b_irq_req)
    else $error("timer B overflow flag not set");
  chk_bus_answer: assert property (@(posedge clock) disable iff (sys_rst)
    (read || write) && bus_state_ff == BUS_IDLE |=> !waitrequest)
    else $error("bus answer late");
  chk_tmr_vector: assert property (@(posedge clock) disable iff (sys_rst)
    vector_ack[EV_TMR_A] && !tf_a_set |=> !tf_a_ff)
    else $error("timer A flag not cleared by vector");
  chk_pin_b_vector: assert property (@(posedge clock) disable iff (sys_rst)
    vector_ack[EV_PIN_B] && !ie_b_set |=> !ie_b_ff)
    else $error("pin B flag not cleared by vector");
  chk_b_split_hold: assert property (@(posedge clock) disable iff (sys_rst)
    mode_b == MODE_SPLIT && !tif_b.wr_low |=> $stable(tif_b.low_q))
    else $error("timer B low byte moved in hold mode");
endmodule : dual_timer_counter_ext_int

// *** tb/pin_partner.sv ***
// far-side model: interrupt pins and count inputs of the timer block
// assumes idle-high lines behind pull-ups, changed right after rising edges
`timescale 1ns/100ps
module pin_partner (
  // clock
  input  wire logic clock,
  // pins toward the block
  output logic      ext_irq_pin_a,
  output logic      ext_irq_pin_b,
  output logic      count_input_a,
  output logic      count_input_b
);
  // irq A, irq B, count A, count B; pull-ups keep them high when idle
  logic [3:0] pin_lvl = 4'hF;
  assign {count_input_b, count_input_a, ext_irq_pin_b, ext_irq_pin_a} = pin_lvl;
  // hold one line at a level
  task automatic set_pin(input int idx, input logic lvl);
    @(posedge clock);
    pin_lvl[idx] <= lvl;
  endtask : set_pin
  // n falls, each low for w clocks; short w models a hasty source
  task automatic pulse(input int idx, input int n, input int w);
    repeat (n) begin
      @(posedge clock);
      pin_lvl[idx] <= 1'h0;
      repeat (w) @(posedge clock);
      pin_lvl[idx] <= 1'h1;
      repeat (3) @(posedge clock);
    end
  endtask : pulse
endmodule : pin_partner

// *** tb/dual_timer_counter_ext_int_test.sv ***
// self-checking bench: register bus, counting modes, pin sensing, interrupts
// assumes pin_partner drives the pins; the bench drives bus and acks
`timescale 1ns/100ps
module dual_timer_counter_ext_int_test;
  import tmr_pkg::*;
  logic        clock = 1'h0;      // system clock
  logic        sys_rst = 1'h1;    // reset, held 8 clocks
  logic [11:0] address = 12'h000; // bus request
  logic        read = 1'h0;
  logic        write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        pin_a, pin_b, cnt_a, cnt_b; // from the pin model
  logic [3:0]  vector_ack = 4'h0;
  wire  [3:0]  req;               // requests by event index
  logic        irq;
  logic [7:0]  rv, lo, nb;        // read value, low index, random count
  int          error_cnt = 0;
  int          checks_done = 0;
  // 125 MHz
  always #4 clock = ~clock;
  pin_partner i_pin_partner (.clock(clock), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
    .count_input_a(cnt_a), .count_input_b(cnt_b));
  dual_timer_counter_ext_int i_dual_timer_counter_ext_int (.clock(clock), .sys_rst(sys_rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b), .count_input_a(cnt_a),
    .count_input_b(cnt_b), .vector_ack(vector_ack), .timer_a_irq_req(req[EV_TMR_A]),
    .timer_b_irq_req(req[EV_TMR_B]), .pin_a_irq_req(req[EV_PIN_A]),
    .pin_b_irq_req(req[EV_PIN_B]), .irq(irq));
  // one timer's nibble of the mode byte, other timer in mode 00
  function automatic logic [7:0] mode_byte(input int t, input logic g, input logic s,
                                          input logic [1:0] m);
    return (t == 1) ? ({4'h0, g, s, m} << MODE_B_LSB) : {4'h0, g, s, m};
  endfunction : mode_byte
  // run bit of one timer
  function automatic logic [7:0] run_byte(input int t);
    return (t == 1) ? (8'h01 << BIT_TR_B) : (8'h01 << BIT_TR_A);
  endfunction : run_byte
  // compare and count
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check_val
  // one bus cycle; held until waitrequest is sampled low
  task automatic bus(input logic is_rd, input logic [7:0] idx, input logic [7:0] wd);
    int w;
    w = 0;
    @(posedge clock);
    address <= {2'h0, idx, 2'h0};
    writedata <= {24'h0, wd};
    read <= is_rd;
    write <= ~is_rd;
    @(posedge clock);
    while (waitrequest !== 1'h0 && w < 50) begin
      @(posedge clock);
      w++;
    end
    if (w >= 50) error_cnt++;
    rv = readdata[7:0];
    read <= 1'h0;
    write <= 1'h0;
  endtask : bus
  // service routine entry pulse, then let the clear land
  task automatic ack(input int ev);
    @(posedge clock);
    vector_ack <= 4'h1 << ev;
    @(posedge clock);
    vector_ack <= 4'h0;
    repeat (2) @(posedge clock);
  endtask : ack
  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // watchdog, far beyond the few hundred clocks the tests take
  initial begin
    repeat (30000) @(posedge clock);
    error_cnt++;
    report_and_stop();
  end
  // main sequence
  initial begin
    void'($urandom(7927));
    repeat (8) @(posedge clock);
    sys_rst <= 1'h0;
    // reset values, then an unmapped place
    for (int i = 8'h88; i <= 8'h8D; i++) begin
      bus(1'h1, i[7:0], 8'h00);
      check_val("reset byte", 32'h0, rv);
    end
    bus(1'h1, 8'h40, 8'h00);
    check_val("unmapped", 32'h0, rv);
    // random write then read back of every count byte
    for (int i = 8'h8A; i <= 8'h8D; i++) begin
      nb = 8'($urandom % 256);
      bus(1'h0, i[7:0], nb);
      bus(1'h1, i[7:0], 8'h00);
      check_val("count byte", nb, rv);
    end
    // low lane disabled: the write is answered but changes nothing
    byteenable <= 4'hE;
    bus(1'h0, IDX_B_HIGH, ~nb);
    byteenable <= 4'hF;
    bus(1'h1, IDX_B_HIGH, 8'h00);
    check_val("lane off", nb, rv);
    // counter mode with pin gating, both timers
    for (int t = 0; t < 2; t++) begin
      lo = (t == 1) ? IDX_B_LOW : IDX_A_LOW;
      bus(1'h0, IDX_MODE_CTRL, mode_byte(t, 1'h1, 1'h1, MODE_WIDE));
      bus(1'h0, lo, 8'h00);
      i_pin_partner.set_pin(t, 1'h0);
      bus(1'h0, IDX_RUN_FLAGS, run_byte(t));
      i_pin_partner.pulse(2 + t, 3, 2);
      bus(1'h1, lo, 8'h00);
      check_val("gated low", 32'h0, rv);
      i_pin_partner.set_pin(t, 1'h1);
      nb = 8'(1 + $urandom % 8);
      i_pin_partner.pulse(2 + t, nb, 1 + t);
      bus(1'h1, lo, 8'h00);
      check_val("pin falls", nb, rv);
      bus(1'h0, IDX_RUN_FLAGS, 8'h00);
      i_pin_partner.pulse(2 + t, 2, 2);
      bus(1'h1, lo, 8'h00);
      check_val("stopped", nb, rv);
    end
    // timer rate: about 43 clocks of running
    bus(1'h0, IDX_MODE_CTRL, mode_byte(0, 1'h0, 1'h0, MODE_WIDE));
    bus(1'h0, IDX_A_LOW, 8'h00);
    bus(1'h0, IDX_RUN_FLAGS, run_byte(0));
    repeat (40) @(posedge clock);
    bus(1'h0, IDX_RUN_FLAGS, 8'h00);
    bus(1'h1, IDX_A_LOW, 8'h00);
    check_val("half rate", 32'h1, {31'h0, rv >= 8'h14 && rv <= 8'h17});
    // prescaled, wide and reload modes from a full low byte
    for (int k = 0; k < 3; k++) begin
      bus(1'h0, IDX_MODE_CTRL, mode_byte(0, 1'h0, 1'h0, k[1:0]));
      bus(1'h0, IDX_A_LOW, 8'hFF);
      nb = (k == 0) ? 8'h05 : (k == 1) ? 8'h12 : 8'hA0;
      bus(1'h0, IDX_A_HIGH, nb);
      bus(1'h0, IDX_RUN_FLAGS, run_byte(0));
      repeat (3) @(posedge clock);
      check_val("A flag", {31'h0, k == 2}, {31'h0, req[EV_TMR_A]});
      if (k == 2) ack(EV_TMR_A);
      check_val("A flag ack", 32'h0, {31'h0, req[EV_TMR_A]});
      bus(1'h0, IDX_RUN_FLAGS, 8'h00);
      bus(1'h1, IDX_A_HIGH, 8'h00);
      check_val("A high", (k == 2) ? nb : nb + 8'h01, rv);
      bus(1'h1, IDX_A_LOW, 8'h00);
      if (k == 2) check_val("reloaded", 8'hA0, rv & 8'hF8);
    end
    // split mode: A high byte runs on B's run bit and B's flag; B holds
    bus(1'h0, IDX_A_HIGH, 8'hFF);
    bus(1'h0, IDX_A_LOW, 8'h00);
    bus(1'h0, IDX_B_LOW, nb);
    bus(1'h0, IDX_MODE_CTRL, 8'h33);
    bus(1'h0, IDX_RUN_FLAGS, run_byte(1));
    repeat (4) @(posedge clock);
    check_val("B flag split", 32'h1, {31'h0, req[EV_TMR_B]});
    bus(1'h0, IDX_RUN_FLAGS, 8'h00);
    bus(1'h1, IDX_A_LOW, 8'h00);
    check_val("A low idle", 32'h0, rv);
    bus(1'h1, IDX_B_LOW, 8'h00);
    check_val("B held", nb, rv);
    // pins: level then edge sense, flag, mask, ack, clear
    for (int p = 0; p < 2; p++) begin
      i_pin_partner.set_pin(p, 1'h0);
      repeat (5) @(posedge clock);
      check_val("level low", 32'h1, {31'h0, req[EV_PIN_A + p]});
      i_pin_partner.set_pin(p, 1'h1);
      repeat (5) @(posedge clock);
      check_val("level high", 32'h0, {31'h0, req[EV_PIN_A + p]});
      bus(1'h0, IDX_RUN_FLAGS, 8'h01 << ((p == 1) ? BIT_IT_B : BIT_IT_A));
      bus(1'h0, IDX_IRQ_STATUS, 8'h0F);
      bus(1'h0, IDX_IRQ_MASK, 8'h01 << (EV_PIN_A + p));
      check_val("irq quiet", 32'h0, {31'h0, irq});
      i_pin_partner.pulse(p, 1, 3);
      check_val("edge req", 32'h1, {31'h0, req[EV_PIN_A + p]});
      check_val("irq set", 32'h1, {31'h0, irq});
      ack(EV_PIN_A + p);
      check_val("edge acked", 32'h0, {31'h0, req[EV_PIN_A + p]});
      bus(1'h0, IDX_IRQ_STATUS, 8'h0F);
      repeat (2) @(posedge clock);
      check_val("irq cleared", 32'h0, {31'h0, irq});
      bus(1'h0, IDX_IRQ_MASK, 8'h00);
    end
    report_and_stop();
  end
endmodule : dual_timer_counter_ext_int_test
